// >>> rtl/egb_cfg.svh
// constants of the echo gain and burst configuration bank
`ifndef EGB_CFG_SVH
`define EGB_CFG_SVH
// register offsets
`define EGB_OFS_GAIN_PT_ONE_TWO 8'h17
`define EGB_OFS_GAIN_PT_TWO_THREE 8'h18
`define EGB_OFS_GAIN_PT_THREE_FOUR 8'h19
`define EGB_OFS_GAIN_PT_FIVE_SHIFT 8'h1a
`define EGB_OFS_INIT_GAIN_FILTER 8'h1b
`define EGB_OFS_BURST_RATE 8'h1c
`define EGB_OFS_PULSE_GAP_DEGLITCH 8'h1d
`define EGB_OFS_PRESET_ONE_PIN_CTRL 8'h1e
`define EGB_OFS_STATUS 8'h3f
`define EGB_REG_COUNT 8
`define EGB_RESET_VAL 8'h00
// field positions
`define EGB_POS_SHIFT 0
`define EGB_POS_STAT_PENDING 0
`define EGB_POS_STAT_BURST_RATE_CODE_BAD 1
`define EGB_POS_IF_SEL 7
`define EGB_POS_DIAG_PAGE 6
`define EGB_POS_XCVR_OFF 5
// burst rate law, in fifths of a kilohertz
`define EGB_BURST_RATE_CODE_MAX 8'hfa
`define EGB_BURST_RATE_CODE_BASE_FIFTHS 12'h096
`define EGB_SHIFT_MULT 12'h006
// timing
`define EGB_CLK_NS 40
`define EGB_CLK_PS 40000
`define EGB_DEGLITCH_STEP_NS 8000
`define EGB_DEAD_STEP_PS 62500
`define EGB_DEGLITCH_STEP_CYC ((`EGB_DEGLITCH_STEP_NS + `EGB_CLK_NS - 1) / `EGB_CLK_NS)
`endif

// >>> rtl/egb_pkg.sv
// types of the echo gain and burst configuration bank
package egb_pkg;
  // settings handed to the measurement engine
  typedef struct packed {
    logic [4:0][9:0] ramp_gain_hdb;
    logic [9:0] init_gain_hdb;
    logic [3:0] bandpass_width_khz;
    logic [11:0] burst_rate_fifths;
    logic [11:0] deglitch_cycles;
    logic [4:0] pulse_gap_cycles;
    logic uart_mode;
    logic xcvr_enable;
    logic diag_page_system;
    logic [4:0] pulse_count;
    logic single_pulse_a_only;
  } egb_settings_t;
  // register access request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } egb_bus_t;
endpackage : egb_pkg

// >>> rtl/egb_config_regs.sv
// echo gain and burst configuration register bank
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "egb_cfg.svh"

// Overview of operation
// RULE1: each gain point yields half a dB per code step plus one, plus range offset
// RULE2: first gain point is bits 7:2 of offset 17h
// RULE3: second gain point: low bits 1:0 at 17h, upper bits 7:4 at 18h
// RULE4: third gain point: bits 3:0 at 18h low, bits 7:6 at 19h high
// RULE5: fourth gain point is bits 5:0 of offset 19h
// RULE6: fifth gain point is bits 7:2 of 1ah; bit 1 spare but read/write
// RULE7: shift bit 0 of 1ah multiplies burst rate by six
// RULE8: bits 7:6 of 1bh give bandpass width of two times code plus one kHz
// RULE9: bits 5:0 of 1bh give initial gain with the gain point law
// RULE10: offset 1ch code gives burst rate of 0.2 kHz per step plus 30 kHz
// RULE11: software writes burst rate codes only up to 250
// RULE12: bits 7:4 of 1dh give deglitch period of code times 8 us
// RULE13: bits 3:0 of 1dh give pulse gap of code times 0.0625 us
// RULE14: 1eh holds interface select, diag page, transceiver off, pulse count
// RULE15: all eight registers reset to zero and are fully read/write
// RULE16: interface select clear means time-based, set means one-wire uart
// RULE17: transceiver off bit acts only while time-based interface is selected
// RULE18: pulse count zero gives one pulse on driver output a only
// RULE19: diag page clear shows uart diagnostics, set shows system diagnostics
// RULE20: new values take effect only between measurements, never during one
module egb_config_regs #(
  parameter int REG_COUNT = `EGB_REG_COUNT
) (
  input wire logic clk,
  input wire logic srst,
  input wire egb_pkg::egb_bus_t bus,
  input wire logic measure_busy,
  input wire logic [7:0] front_end_gain_range_db,
  output logic [7:0] rdata,
  output egb_pkg::egb_settings_t settings,
  output logic update_pending,
  output logic burst_rate_code_code_invalid
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // true when the address falls inside the configuration window
  function automatic logic in_bank(input logic [7:0] addr);
    logic [8:0] top;
    top = {1'b0, `EGB_OFS_GAIN_PT_ONE_TWO} + 9'(REG_COUNT);
    in_bank = (addr >= `EGB_OFS_GAIN_PT_ONE_TWO) && ({1'b0, addr} < top);
  endfunction : in_bank

  // index of a register inside the window
  function automatic logic [2:0] bank_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `EGB_OFS_GAIN_PT_ONE_TWO;
    bank_index = diff[2:0];
  endfunction : bank_index

  // gain law in half-dB units: code plus one, plus twice the range offset
  function automatic logic [9:0] gain_hdb(input logic [5:0] code, input logic [7:0] ofs);
    logic [9:0] g;
    g = 10'({4'h0, code}) + 10'h001 + {1'b0, ofs, 1'b0};
    gain_hdb = g;
  endfunction : gain_hdb

  // pulse gap in clock cycles, rounded up so the gap is never short
  function automatic logic [4:0] gap_cycles(input logic [3:0] code);
    int t;
    t = (int'(code) * `EGB_DEAD_STEP_PS + `EGB_CLK_PS - 1) / `EGB_CLK_PS;
    gap_cycles = t[4:0];
  endfunction : gap_cycles

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] regs [REG_COUNT];
  logic wr_hit;
  logic rd_hit;
  logic [2:0] hit_idx;

  // shared decode of the current access
  assign wr_hit = bus.wr && in_bank(bus.addr);
  assign rd_hit = bus.rd && in_bank(bus.addr);
  assign hit_idx = bank_index(bus.addr);

  // one write port per register; every bit, spare ones too, is stored
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi = gi + 1) begin : g_reg
      always_ff @(posedge clk) begin
        if (srst) begin
          regs[gi] <= `EGB_RESET_VAL; // RULE15
        end else if (wr_hit && (hit_idx == 3'(gi))) begin
          regs[gi] <= bus.wdata; // RULE15 RULE6
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // field extraction from the staged registers

  logic [4:0][5:0] pt_code;
  logic [5:0] init_code;
  logic [1:0] bw_code;
  logic [7:0] rate_code;
  logic rate_shift;
  logic [3:0] deglitch_code;
  logic [3:0] gap_code;
  logic [7:0] pin_ctrl;

  // gain points; split fields keep the earlier register as the low part
  assign pt_code[0] = regs[0][7:2]; // RULE2
  assign pt_code[1] = {regs[1][7:4], regs[0][1:0]}; // RULE3
  assign pt_code[2] = {regs[2][7:6], regs[1][3:0]}; // RULE4
  assign pt_code[3] = regs[2][5:0]; // RULE5
  assign pt_code[4] = regs[3][7:2]; // RULE6

  // remaining codes
  assign rate_shift = regs[3][`EGB_POS_SHIFT]; // RULE7
  assign bw_code = regs[4][7:6]; // RULE8
  assign init_code = regs[4][5:0]; // RULE9
  assign rate_code = regs[5]; // RULE10
  assign deglitch_code = regs[6][7:4]; // RULE12
  assign gap_code = regs[6][3:0]; // RULE13
  assign pin_ctrl = regs[7]; // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // settings computed from the staged codes

  egb_pkg::egb_settings_t next_settings;
  logic [11:0] base_fifths;

  // the engine gets ready-made quantities, not raw codes
  always_comb begin
    next_settings = '0;
    base_fifths = {4'h0, rate_code} + `EGB_BURST_RATE_CODE_BASE_FIFTHS; // RULE10
    for (int i = 0; i < 5; i++) begin
      next_settings.ramp_gain_hdb[i] = gain_hdb(pt_code[i], front_end_gain_range_db); // RULE1
    end
    next_settings.init_gain_hdb = gain_hdb(init_code, front_end_gain_range_db); // RULE9
    next_settings.bandpass_width_khz = {1'b0, bw_code, 1'b0} + 4'h2; // RULE8
    if (rate_shift) begin
      next_settings.burst_rate_fifths = 12'(base_fifths * `EGB_SHIFT_MULT); // RULE7
    end else begin
      next_settings.burst_rate_fifths = base_fifths;
    end
    next_settings.deglitch_cycles = 12'(int'(deglitch_code) * `EGB_DEGLITCH_STEP_CYC); // RULE12
    next_settings.pulse_gap_cycles = gap_cycles(gap_code); // RULE13
    next_settings.uart_mode = pin_ctrl[`EGB_POS_IF_SEL]; // RULE16
    // disabling the transceiver would cut off a uart link, so it is ignored there
    next_settings.xcvr_enable = pin_ctrl[`EGB_POS_IF_SEL] | ~pin_ctrl[`EGB_POS_XCVR_OFF]; // RULE17
    next_settings.diag_page_system = pin_ctrl[`EGB_POS_DIAG_PAGE]; // RULE19
    if (pin_ctrl[4:0] == 5'h00) begin
      next_settings.pulse_count = 5'h01; // RULE18
      next_settings.single_pulse_a_only = 1'b1; // RULE18
    end else begin
      next_settings.pulse_count = pin_ctrl[4:0];
      next_settings.single_pulse_a_only = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active settings, frozen while a measurement runs

  // tracking every idle cycle avoids a separate apply strobe from software
  always_ff @(posedge clk) begin
    if (srst) begin
      settings <= '0;
    end else if (!measure_busy) begin
      settings <= next_settings; // RULE20
    end
  end

  // a write during a measurement waits; the set beats the idle release
  always_ff @(posedge clk) begin
    if (srst) begin
      update_pending <= 1'b0;
    end else if (wr_hit && measure_busy) begin
      update_pending <= 1'b1; // RULE20
    end else if (!measure_busy) begin
      update_pending <= 1'b0;
    end
  end

  // out-of-range rate codes are stored but flagged for software
  always_ff @(posedge clk) begin
    if (srst) begin
      burst_rate_code_code_invalid <= 1'b0;
    end else begin
      burst_rate_code_code_invalid <= rate_code > `EGB_BURST_RATE_CODE_MAX; // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  // read data stand one cycle after the strobe and only then
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd_hit) begin
      rdata <= regs[hit_idx]; // RULE15
    end else if (bus.rd && (bus.addr == `EGB_OFS_STATUS)) begin
      rdata <= 8'h00;
      rdata[`EGB_POS_STAT_PENDING] <= update_pending;
      rdata[`EGB_POS_STAT_BURST_RATE_CODE_BAD] <= burst_rate_code_code_invalid;
    end else begin
      rdata <= 8'h00; // unmapped or idle reads give zero
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // follows reset by one edge; the release edge still stores reset values,
  // so no check may compare against the registers sampled there
  logic rst_trail;

  always_ff @(posedge clk) begin
    rst_trail <= srst;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst || rst_trail);

  sequence s_idle_two;
    !measure_busy ##1 !measure_busy;
  endsequence

  sequence s_busy_two;
    measure_busy ##1 measure_busy;
  endsequence

  a_write_then_read: assert property ( // RULE15
    wr_hit ##1 (bus.rd && bus.addr == $past(bus.addr))
    |=> rdata == $past(bus.wdata, 2))
  else $error("read after write does not return written byte");

  a_unmapped_zero: assert property ( // RULE15
    (bus.rd && !in_bank(bus.addr) && bus.addr != `EGB_OFS_STATUS) |=> rdata == 8'h00)
  else $error("unmapped read not zero");

  a_reset_clears: assert property (@(posedge clk) disable iff (1'b0) // RULE15
    srst |=> (regs[0] == 8'h00 && regs[7] == 8'h00 && rdata == 8'h00))
  else $error("reset left register content");

  a_point_one_gain: assert property ( // RULE1 RULE2
    s_idle_two |-> settings.ramp_gain_hdb[0] ==
      10'($past(regs[0][7:2])) + 10'h001 + {1'b0, $past(front_end_gain_range_db), 1'b0})
  else $error("first gain point wrong");

  a_split_points: assert property ( // RULE3 RULE5
    !measure_busy |=> (settings.ramp_gain_hdb[1][5:0] ==
      6'({$past(regs[1][7:4]), $past(regs[0][1:0])} + 6'h01 + {$past(front_end_gain_range_db[4:0]), 1'b0})
      && settings.ramp_gain_hdb[3][0] == ~$past(regs[2][0])))
  else $error("split gain point wrong");

  a_rate_shift: assert property ( // RULE7 RULE10
    !measure_busy |=> settings.burst_rate_fifths ==
      ($past(regs[3][0]) ? 12'(({4'h0, $past(regs[5])} + 12'h096) * 12'h006)
                         : {4'h0, $past(regs[5])} + 12'h096))
  else $error("burst rate wrong");

  a_bandwidth: assert property ( // RULE8
    !measure_busy |=> settings.bandpass_width_khz == {1'b0, $past(regs[4][7:6]), 1'b0} + 4'h2)
  else $error("bandpass width wrong");

  a_deglitch_gap: assert property ( // RULE12 RULE13
    !measure_busy |=> (settings.deglitch_cycles == 12'(int'($past(regs[6][7:4])) * 200)
      && (settings.pulse_gap_cycles == 5'h00) == ($past(regs[6][3:0]) == 4'h0)))
  else $error("deglitch or gap timing wrong");

  a_pin_control: assert property ( // RULE16 RULE17 RULE19
    !measure_busy |=> (settings.uart_mode == $past(regs[7][7])
      && settings.diag_page_system == $past(regs[7][6])
      && settings.xcvr_enable == ($past(regs[7][7]) || !$past(regs[7][5]))))
  else $error("pin control wrong");

  a_single_pulse: assert property ( // RULE18
    (!measure_busy && regs[7][4:0] == 5'h00) |=>
      (settings.single_pulse_a_only && settings.pulse_count == 5'h01))
  else $error("zero pulse count not single pulse");

  a_hold_busy: assert property ( // RULE20
    s_busy_two |-> $stable(settings))
  else $error("settings moved during measurement");

  a_pending_clear: assert property ( // RULE20
    (update_pending && !measure_busy) |=> !update_pending)
  else $error("pending flag not released when idle");

  a_burst_rate_code_flag: assert property ( // RULE11
    ##1 burst_rate_code_code_invalid == ($past(regs[5]) > 8'hfa))
  else $error("rate code range flag wrong");

  // bus side: bytes land where addressed and read data stand one cycle
  a_write_lands: assert property ( // RULE15 RULE6
    wr_hit |=> regs[$past(hit_idx)] == $past(bus.wdata))
  else $error("written byte not stored");

  // a stray write outside the window must not disturb any byte
  a_unmapped_write: assert property ( // RULE15
    (bus.wr && !in_bank(bus.addr)) |=>
      $stable({regs[0], regs[1], regs[2], regs[3], regs[4], regs[5], regs[6], regs[7]}))
  else $error("write outside the window changed a register");

  a_rdata_idle: assert property ( // RULE15
    !bus.rd |=> rdata == 8'h00)
  else $error("read data stand without a read");

  a_status_read: assert property ( // RULE20 RULE11
    (bus.rd && bus.addr == `EGB_OFS_STATUS) |=>
      rdata == {6'h00, $past(burst_rate_code_code_invalid), $past(update_pending)})
  else $error("status read wrong");

  // settings side: fields other than the first gain point, bandpass width and diag page against their own law
  a_mid_points: assert property ( // RULE1 RULE3 RULE4
    !measure_busy |=>
      (settings.ramp_gain_hdb[1] == 10'({$past(regs[1][7:4]), $past(regs[0][1:0])})
        + 10'h001 + {1'b0, $past(front_end_gain_range_db), 1'b0})
      && (settings.ramp_gain_hdb[2] == 10'({$past(regs[2][7:6]), $past(regs[1][3:0])})
        + 10'h001 + {1'b0, $past(front_end_gain_range_db), 1'b0}))
  else $error("middle gain points wrong");

  a_outer_points: assert property ( // RULE1 RULE5 RULE6
    !measure_busy |=>
      (settings.ramp_gain_hdb[3] == 10'($past(regs[2][5:0]))
        + 10'h001 + {1'b0, $past(front_end_gain_range_db), 1'b0})
      && (settings.ramp_gain_hdb[4] == 10'($past(regs[3][7:2]))
        + 10'h001 + {1'b0, $past(front_end_gain_range_db), 1'b0}))
  else $error("outer gain points wrong");

  a_init_gain: assert property ( // RULE9
    !measure_busy |=> settings.init_gain_hdb ==
      10'($past(regs[4][5:0])) + 10'h001 + {1'b0, $past(front_end_gain_range_db), 1'b0})
  else $error("initial gain wrong");

  // plain rate law when the range bit is clear
  a_rate_plain: assert property ( // RULE7 RULE10
    (!measure_busy && !regs[3][`EGB_POS_SHIFT]) |=>
      settings.burst_rate_fifths == {4'h0, $past(regs[5])} + `EGB_BURST_RATE_CODE_BASE_FIFTHS)
  else $error("burst rate shifted without the range bit");

  a_deglitch_span: assert property ( // RULE12
    !measure_busy |=> int'(settings.deglitch_cycles) * `EGB_CLK_NS ==
      int'($past(regs[6][7:4])) * `EGB_DEGLITCH_STEP_NS)
  else $error("deglitch span not code times step");

  // rounding up keeps the gap from ever falling short of the code
  a_gap_bound: assert property ( // RULE13
    !measure_busy |=>
      (int'(settings.pulse_gap_cycles) * `EGB_CLK_PS >=
        int'($past(regs[6][3:0])) * `EGB_DEAD_STEP_PS)
      && (int'(settings.pulse_gap_cycles) * `EGB_CLK_PS <
        int'($past(regs[6][3:0])) * `EGB_DEAD_STEP_PS + `EGB_CLK_PS))
  else $error("pulse gap not the shortest covering count");

  a_pulse_count: assert property ( // RULE14 RULE18
    (!measure_busy && regs[7][4:0] != 5'h00) |=>
      (!settings.single_pulse_a_only && settings.pulse_count == $past(regs[7][4:0])))
  else $error("preset pulse count wrong");

  a_xcvr_off: assert property ( // RULE17
    (!measure_busy && !regs[7][`EGB_POS_IF_SEL] && regs[7][`EGB_POS_XCVR_OFF]) |=>
      !settings.xcvr_enable)
  else $error("transceiver stays on in time-based mode");

  // uart mode must keep its pin alive whatever the off bit says
  a_xcvr_uart: assert property ( // RULE16 RULE17
    (!measure_busy && regs[7][`EGB_POS_IF_SEL]) |=> (settings.xcvr_enable && settings.uart_mode))
  else $error("uart link lost its transceiver");

  // deferral: the pending flag rises on a held write and stays up while busy
  a_pending_set: assert property ( // RULE20
    (wr_hit && measure_busy) |=> update_pending)
  else $error("write during measurement not flagged");

  a_pending_hold: assert property ( // RULE20
    (update_pending && measure_busy) |=> update_pending)
  else $error("pending flag dropped during measurement");

endmodule : egb_config_regs

// >>> verification/testbench.sv
// self-checking bench for the echo gain and burst configuration bank
`timescale 1ns/100ps
`include "egb_cfg.svh"

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
  logic clk;
  logic srst;
  logic measure_busy;
  logic [7:0] fe_db;
  logic [7:0] rdata;
  logic update_pending;
  logic burst_rate_code_code_invalid;
  egb_pkg::egb_bus_t bus;
  egb_pkg::egb_settings_t settings;
  egb_pkg::egb_settings_t exp_s;
  logic [7:0] r [8];
  logic [7:0] seed;
  logic [7:0] v;
  int mismatches;
  int compares;

  egb_config_regs egb_config_regs_inst (
    .clk(clk),
    .srst(srst),
    .bus(bus),
    .measure_busy(measure_busy),
    .front_end_gain_range_db(fe_db),
    .rdata(rdata),
    .settings(settings),
    .update_pending(update_pending),
    .burst_rate_code_code_invalid(burst_rate_code_code_invalid)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // pseudo random source, shift left with tap feedback
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // expected settings from the register copy and the range offset
  function automatic egb_pkg::egb_settings_t model();
    egb_pkg::egb_settings_t s;
    logic [5:0] g [5];
    g[0] = r[0][7:2];
    g[1] = {r[1][7:4], r[0][1:0]};
    g[2] = {r[2][7:6], r[1][3:0]};
    g[3] = r[2][5:0];
    g[4] = r[3][7:2];
    s = '0;
    for (int i = 0; i < 5; i++) s.ramp_gain_hdb[i] = 10'(g[i]) + 10'h001 + {1'b0, fe_db, 1'b0};
    s.init_gain_hdb = 10'(r[4][5:0]) + 10'h001 + {1'b0, fe_db, 1'b0};
    s.bandpass_width_khz = 4'((r[4][7:6] + 4'h1) * 4'h2);
    s.burst_rate_fifths = 12'((r[5] + `EGB_BURST_RATE_CODE_BASE_FIFTHS) * (r[3][0] ? `EGB_SHIFT_MULT : 1));
    s.deglitch_cycles = 12'(r[6][7:4] * 12'h0c8);
    s.pulse_gap_cycles = 5'((r[6][3:0] * 16'h0271 + 16'h018f) / 16'h0190);
    s.uart_mode = r[7][7];
    s.diag_page_system = r[7][6];
    s.xcvr_enable = r[7][7] | ~r[7][5];
    s.pulse_count = (r[7][4:0] == 5'h00) ? 5'h01 : r[7][4:0];
    s.single_pulse_a_only = (r[7][4:0] == 5'h00);
    return s;
  endfunction : model

  // one write cycle; the local copy follows mapped offsets only
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    if (a >= 8'h17 && a <= 8'h1e) r[a - 8'h17] = d;
  endtask : wr_reg

  // one read cycle, data checked in the following cycle, then back to zero
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 `CHK("rdata", e, rdata)
    @(posedge clk);
    #1 `CHK("rdata_idle", 8'h00, rdata)
  endtask : rd_chk

  // field by field comparison with the model
  task automatic chk_settings();
    exp_s = model();
    `CHK("ramp_gain", exp_s.ramp_gain_hdb, settings.ramp_gain_hdb)
    `CHK("init_gain", exp_s.init_gain_hdb, settings.init_gain_hdb)
    `CHK("bandpass", exp_s.bandpass_width_khz, settings.bandpass_width_khz)
    `CHK("burst_rate", exp_s.burst_rate_fifths, settings.burst_rate_fifths)
    `CHK("deglitch", exp_s.deglitch_cycles, settings.deglitch_cycles)
    `CHK("pulse_gap", exp_s.pulse_gap_cycles, settings.pulse_gap_cycles)
    `CHK("uart_mode", exp_s.uart_mode, settings.uart_mode)
    `CHK("xcvr_enable", exp_s.xcvr_enable, settings.xcvr_enable)
    `CHK("diag_page", exp_s.diag_page_system, settings.diag_page_system)
    `CHK("pulse_count", exp_s.pulse_count, settings.pulse_count)
    `CHK("single_a", exp_s.single_pulse_a_only, settings.single_pulse_a_only)
  endtask : chk_settings

  // verdict and end of run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////////////
  // watchdog so a stuck sequence still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    bus = '0;
    measure_busy = 1'b0;
    fe_db = 8'h00;
    seed = 8'h46;
    mismatches = 0;
    compares = 0;
    for (int k = 0; k < 8; k++) r[k] = 8'h00;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 8; k++) rd_chk(8'h17 + 8'(k), 8'h00);
    rd_chk(`EGB_OFS_STATUS, 8'h00);
    #1 chk_settings();
    $display("test reset done");
    // first round all ones hits every field maximum, the rate code only its limit of 250; the rest are random
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      @(posedge clk);
      fe_db <= seed;
      for (int k = 0; k < 8; k++) begin
        seed = lfsr(seed);
        v = (n == 0) ? 8'hff : seed;
        wr_reg(8'h17 + 8'(k), (k == 5 && v > `EGB_BURST_RATE_CODE_MAX) ? `EGB_BURST_RATE_CODE_MAX : v);
      end
      for (int k = 0; k < 8; k++) rd_chk(8'h17 + 8'(k), r[k]);
      #1 chk_settings();
    end
    $display("test fields done");
    // a write during a measurement must wait for the idle gap
    exp_s = model();
    @(posedge clk);
    measure_busy <= 1'b1;
    wr_reg(`EGB_OFS_PRESET_ONE_PIN_CTRL, ~r[7]);
    repeat (3) @(posedge clk);
    #1 `CHK("held", exp_s, settings)
    `CHK("pending", 1'b1, update_pending)
    rd_chk(`EGB_OFS_STATUS, 8'h01);
    @(posedge clk);
    measure_busy <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk_settings();
    `CHK("pending_clr", 1'b0, update_pending)
    $display("test deferral done");
    // rate code just past and at the valid limit
    wr_reg(`EGB_OFS_BURST_RATE, 8'hfb);
    @(posedge clk);
    #1 `CHK("burst_rate_code_bad", 1'b1, burst_rate_code_code_invalid)
    rd_chk(`EGB_OFS_STATUS, 8'h02);
    wr_reg(`EGB_OFS_BURST_RATE, `EGB_BURST_RATE_CODE_MAX);
    @(posedge clk);
    #1 `CHK("burst_rate_code_ok", 1'b0, burst_rate_code_code_invalid)
    $display("test rate limit done");
    // unmapped places read zero and writes there change nothing
    wr_reg(8'h20, 8'h5a);
    wr_reg(8'h16, 8'ha5);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h16, 8'h00);
    for (int k = 0; k < 8; k++) rd_chk(8'h17 + 8'(k), r[k]);
    $display("test unmapped done");
    // write then read with no idle cycle between, then a reset in mid-run
    seed = lfsr(seed);
    @(posedge clk);
    bus <= '{`EGB_OFS_PULSE_GAP_DEGLITCH, seed, 1'b1, 1'b0};
    r[6] = seed;
    @(posedge clk);
    bus <= '{`EGB_OFS_PULSE_GAP_DEGLITCH, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 `CHK("rdata_b2b", r[6], rdata)
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 8; k++) r[k] = 8'h00;
    for (int k = 0; k < 8; k++) rd_chk(8'h17 + 8'(k), 8'h00);
    #1 chk_settings();
    `CHK("pending_rst", 1'b0, update_pending)
    $display("test back to back and reset done");
    end_of_test();
  end
endmodule : testbench
